//--- include/vips_cfg.svh
/*
 * Constants for the vectored interrupt priority and state block:
 * register offsets, field positions, reset values.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef VIPS_CFG_SVH
`define VIPS_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define VIPS_NUM_IRQ 32
`define VIPS_IDX_W 5
`define VIPS_PRIO_W 2
`define VIPS_ADDR_W 12
`define VIPS_NUM_PRIO_REG 8

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define VIPS_OFS_ENA_SET 12'h100
`define VIPS_OFS_ENA_CLR 12'h180
`define VIPS_OFS_PEND_SET 12'h200
`define VIPS_OFS_PEND_CLR 12'h280
`define VIPS_OFS_ACTIVE 12'h300
`define VIPS_OFS_LEVEL_MODE 12'h380
`define VIPS_OFS_PRIO_BASE 12'h400
`define VIPS_OFS_PRIO_LAST 12'h41c

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define VIPS_PRIO_LSB 6
`define VIPS_LANE_W 8
`define VIPS_RST_WORD 32'h0000_0000
`define VIPS_RST_PRIO 2'h0

`endif

//--- include/vips_pkg.sv
/*
 * Types shared by the vectored interrupt priority and state block.
 * Assumes vips_cfg.svh is on the include path.
 */
`include "vips_cfg.svh"

package vips_pkg;
    // Per-line state, Gray coded along inactive-pending-active path
    typedef enum logic [1:0] {
        VIPS_INACTIVE = 2'h0,
        VIPS_PENDING = 2'h1,
        VIPS_ACTIVE_PEND = 2'h3,
        VIPS_ACTIVE = 2'h2
    } vips_state_t;

    typedef logic [`VIPS_NUM_IRQ-1:0] vips_vec_t;
    typedef logic [`VIPS_PRIO_W-1:0] vips_prio_t;
    typedef logic [`VIPS_IDX_W-1:0] vips_idx_t;
endpackage

//--- design/vips_prio_mem.sv
/*
 * Priority storage: 32 two-bit priority fields, eight word registers.
 * Read data come out of a register one cycle after the read strobe.
 * Assumes word-only accesses; the host decodes the word index.
 */
`timescale 1ns/1ps
`include "vips_cfg.svh"

module vips_prio_mem
    import vips_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Word port
    input wire logic [2:0] word_idx,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Flat view for the arbiter
    output logic [`VIPS_NUM_IRQ*`VIPS_PRIO_W-1:0] prio_flat
);
    logic [`VIPS_NUM_IRQ*`VIPS_PRIO_W-1:0] prio_ff;
    logic [31:0] rd_data_ff;
    logic [7:0] word_fields;
    logic [31:0] word_view;

    // Fields of the addressed word, two bits per line
    assign word_fields = prio_ff[word_idx*8 +: 8];

    // Only bits 7:6 of each lane exist; the rest read zero
    assign word_view = {word_fields[7:6], 6'h00, word_fields[5:4], 6'h00,
                        word_fields[3:2], 6'h00, word_fields[1:0], 6'h00}; // [RQ4] [RQ5]

    // Store the top two bits of each lane, drop the low six
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prio_ff <= '0;
        end else if (wr_en) begin
            prio_ff[word_idx*8 +: 8] <= {wr_data[31:30], wr_data[23:22],
                                         wr_data[15:14], wr_data[7:6]}; // [RQ1] [RQ4]
        end
    end

    // Registered read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_ff <= `VIPS_RST_WORD;
        end else if (rd_en) begin
            rd_data_ff <= word_view;
        end
    end

    assign rd_data = rd_data_ff;
    assign prio_flat = prio_ff;
endmodule

//--- design/vips_arbiter.sv
/*
 * Picks the enabled pending line with the lowest priority value,
 * lowest line number among equals. Purely combinational.
 * Assumes priority vector and pending/enable masks on the same clock.
 */
`timescale 1ns/1ps
`include "vips_cfg.svh"

module vips_arbiter
    import vips_pkg::*;
(
    // Candidate lines
    input wire logic [`VIPS_NUM_IRQ-1:0] cand,
    input wire logic [`VIPS_NUM_IRQ*`VIPS_PRIO_W-1:0] prio_flat,
    // Winner
    output logic found,
    output logic [`VIPS_IDX_W-1:0] win_idx,
    output logic [`VIPS_PRIO_W-1:0] win_prio
);
    // Scan from the top so the lowest index wins a tie
    always_comb begin
        found = 1'b0;
        win_idx = '0;
        win_prio = '1;
        for (int i = `VIPS_NUM_IRQ - 1; i >= 0; i--) begin
            if (cand[i] && (!found || prio_flat[i*2 +: 2] <= win_prio)) begin // [RQ3] [RQ21]
                found = 1'b1;
                win_idx = i[`VIPS_IDX_W-1:0];
                win_prio = prio_flat[i*2 +: 2];
            end
        end
    end
endmodule

//--- design/vips_top.sv
/*
 * Vectored interrupt priority and state controller, 32 lines.
 * Holds per-line state, enables, priorities and presents the winning
 * pending line to the core. The core acknowledges handler entry and
 * handler exit with one-cycle strobes carrying the line number.
 * Assumes request lines come from logic on ref_clk and a simple
 * register port with read data one cycle after the read strobe.
 */
// Behaviour
// RQ1: Each of 32 lines has a 2-bit priority in eight word registers.
// RQ2: Priority registers are word access only; narrower access unsupported.
// RQ3: Priority 0..3; smaller value wins arbitration.
// RQ4: Only bits 7:6 per lane kept; bits 5:0 read zero, writes dropped.
// RQ5: Line M priority in register M/4, lane M mod 4.
// RQ6: Requests sampled on ref_clk rising edge; pulses are latched.
// RQ7: Pulse sources hold the line at least one clock cycle.
// RQ8: Pending on level while not active, rising edge, or set-pending write.
// RQ9: Handler entry clears pending and marks the line active.
// RQ10: Level line on exit: pending if still asserted, else inactive.
// RQ11: Pulse during active handler makes line active and pending.
// RQ12: No pulse during handler: pulse line inactive on exit.
// RQ13: Clear-pending on asserted level line does nothing, else inactive.
// RQ14: Clear-pending on pulse: pending to inactive, active-pending to active.
// RQ15: Disabled lines still become pending; only taking is blocked.
// RQ16: Software uses aligned accesses only.
// RQ17: 32 lines, four priority levels, level 0 highest.
// RQ18: Enabled pending lines activate by priority; disabled never activate.
// RQ19: Enable set/clear views read enables; ones set or clear, zeros ignored.
// RQ20: Clear-pending never alters the active state.
// RQ21: Among equal top priorities the lowest line number is presented.
`timescale 1ns/1ps
`include "vips_cfg.svh"

module vips_top
    import vips_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [`VIPS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Peripheral request lines
    input wire logic [`VIPS_NUM_IRQ-1:0] irq_req,
    // Core side
    output logic irq_valid,
    output logic [`VIPS_IDX_W-1:0] irq_id,
    output logic [`VIPS_PRIO_W-1:0] irq_prio,
    input wire logic handler_enter,
    input wire logic [`VIPS_IDX_W-1:0] enter_id,
    input wire logic handler_exit,
    input wire logic [`VIPS_IDX_W-1:0] exit_id
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    vips_vec_t req_ff;
    vips_vec_t enable_ff, level_mode_ff, pend_ff, act_ff;
    vips_vec_t nxt_pend, nxt_act, nxt_enable, nxt_level_mode;
    vips_vec_t nxt_req, rise;
    vips_vec_t set_pend_w, clr_pend_w, enter_vec, exit_vec, cand;
    logic [31:0] rd_mux_ff, nxt_rd_mux, prio_rdata;
    logic rd_prio_ff;
    logic [`VIPS_NUM_IRQ*`VIPS_PRIO_W-1:0] prio_flat;
    logic arb_found;
    logic [`VIPS_IDX_W-1:0] arb_idx;
    logic [`VIPS_PRIO_W-1:0] arb_prio;
    logic hit_ena_set, hit_ena_clr, hit_pend_set, hit_pend_clr;
    logic hit_active, hit_level, hit_prio;
    logic prio_wr, prio_rd;
    logic [2:0] prio_word;

    // One-hot of a line number, used for entry and exit strobes
    function automatic vips_vec_t onehot(input vips_idx_t idx);
        vips_vec_t v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Request sampling
    // ----------------------------------------------------------------
    // Lines come from logic on ref_clk, so no synchroniser here.
    // An agreement filter would swallow a pulse one cycle wide.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_ff <= '0;
        end else begin
            req_ff <= nxt_req; // [RQ6]
        end
    end

    // Line level as sampled at this edge
    assign nxt_req = irq_req; // [RQ6]
    // One whole cycle high is enough to show up as a rising edge
    assign rise = nxt_req & ~req_ff;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    assign hit_ena_set = reg_addr == `VIPS_OFS_ENA_SET;
    assign hit_ena_clr = reg_addr == `VIPS_OFS_ENA_CLR;
    assign hit_pend_set = reg_addr == `VIPS_OFS_PEND_SET;
    assign hit_pend_clr = reg_addr == `VIPS_OFS_PEND_CLR;
    assign hit_active = reg_addr == `VIPS_OFS_ACTIVE;
    assign hit_level = reg_addr == `VIPS_OFS_LEVEL_MODE;
    // Aligned words only; low address bits must be zero [RQ2] [RQ16]
    assign hit_prio = reg_addr >= `VIPS_OFS_PRIO_BASE && reg_addr <= `VIPS_OFS_PRIO_LAST
                      && reg_addr[1:0] == 2'h0;
    assign prio_word = reg_addr[4:2]; // [RQ5]
    assign prio_wr = reg_wr && hit_prio;
    assign prio_rd = reg_rd && hit_prio;

    // Write strobes per line
    assign set_pend_w = (reg_wr && hit_pend_set) ? reg_wdata : '0;
    assign clr_pend_w = (reg_wr && hit_pend_clr) ? reg_wdata : '0;
    assign enter_vec = handler_enter ? onehot(enter_id) : '0;
    assign exit_vec = handler_exit ? onehot(exit_id) : '0;

    // ----------------------------------------------------------------
    // Enable and mode registers
    // ----------------------------------------------------------------
    // Ones set or clear; zeros leave enables alone
    always_comb begin
        nxt_enable = enable_ff;
        if (reg_wr && hit_ena_set) begin
            nxt_enable = enable_ff | reg_wdata; // [RQ19]
        end
        if (reg_wr && hit_ena_clr) begin
            nxt_enable = enable_ff & ~reg_wdata; // [RQ19]
        end
        nxt_level_mode = (reg_wr && hit_level) ? reg_wdata : level_mode_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_ff <= `VIPS_RST_WORD;
            level_mode_ff <= `VIPS_RST_WORD;
        end else begin
            enable_ff <= nxt_enable;
            level_mode_ff <= nxt_level_mode;
        end
    end

    // ----------------------------------------------------------------
    // Per-line state
    // ----------------------------------------------------------------
    // Order of events within one cycle: exit, entry, clear, then sets.
    // Hardware sets come last so an event in a clear cycle is kept.
    always_comb begin
        nxt_pend = pend_ff;
        nxt_act = act_ff;
        for (int i = 0; i < `VIPS_NUM_IRQ; i++) begin
            if (exit_vec[i]) begin
                nxt_act[i] = 1'b0;
                if (level_mode_ff[i]) begin
                    nxt_pend[i] = nxt_req[i]; // [RQ10]
                end
                // Pulse line keeps pending only if a pulse came [RQ11] [RQ12]
            end
            if (enter_vec[i]) begin
                nxt_pend[i] = 1'b0; // [RQ9]
                nxt_act[i] = 1'b1; // [RQ9]
            end
            if (clr_pend_w[i]) begin
                // Active bit untouched by a clear [RQ20]
                if (level_mode_ff[i]) begin
                    if (!nxt_req[i]) begin
                        nxt_pend[i] = 1'b0; // [RQ13]
                    end
                end else begin
                    nxt_pend[i] = 1'b0; // [RQ14]
                end
            end
            // Level seen while not active, rising edge, or software set
            if (level_mode_ff[i] && nxt_req[i] && !nxt_act[i]) begin
                nxt_pend[i] = 1'b1; // [RQ8]
            end
            if (!level_mode_ff[i] && rise[i]) begin
                nxt_pend[i] = 1'b1; // [RQ8] [RQ11]
            end
            if (set_pend_w[i]) begin
                nxt_pend[i] = 1'b1; // [RQ8]
            end
        end
    end

    // Enable has no part here: disabled lines still go pending [RQ15]
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_ff <= '0;
            act_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
            act_ff <= nxt_act;
        end
    end

    // ----------------------------------------------------------------
    // Priority store and arbitration
    // ----------------------------------------------------------------
    vips_prio_mem u_prio_mem (
        .ref_clk(ref_clk),
        .rst(rst),
        .word_idx(prio_word),
        .wr_en(prio_wr),
        .wr_data(reg_wdata),
        .rd_en(prio_rd),
        .rd_data(prio_rdata),
        .prio_flat(prio_flat)
    );

    // Only enabled, pending, not yet active lines compete [RQ18]
    assign cand = pend_ff & enable_ff & ~act_ff;

    vips_arbiter u_arbiter (
        .cand(cand),
        .prio_flat(prio_flat),
        .found(arb_found),
        .win_idx(arb_idx),
        .win_prio(arb_prio)
    );

    // Offer to the core, level 0 beats 3 [RQ17] [RQ18]
    assign irq_valid = arb_found;
    assign irq_id = arb_idx;
    assign irq_prio = arb_prio;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Both enable views show enables; both pending views show pending
    always_comb begin
        nxt_rd_mux = '0;
        if (hit_ena_set || hit_ena_clr) begin
            nxt_rd_mux = enable_ff; // [RQ19]
        end else if (hit_pend_set || hit_pend_clr) begin
            nxt_rd_mux = pend_ff;
        end else if (hit_active) begin
            nxt_rd_mux = act_ff;
        end else if (hit_level) begin
            nxt_rd_mux = level_mode_ff;
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_mux_ff <= '0;
            rd_prio_ff <= 1'b0;
        end else begin
            rd_mux_ff <= reg_rd ? nxt_rd_mux : '0;
            rd_prio_ff <= prio_rd;
        end
    end

    assign reg_rdata = rd_prio_ff ? prio_rdata : rd_mux_ff;
endmodule

//--- test/vips_asserts.sv
/* Checker for the interrupt state block: register port and core side.
   Assumes it is bound onto vips_top and sees only its ports. */
`timescale 1ns/1ps
`include "vips_cfg.svh"

module vips_asserts
    import vips_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [`VIPS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Core side
    input wire logic irq_valid,
    input wire logic [`VIPS_IDX_W-1:0] irq_id,
    input wire logic handler_enter,
    input wire logic [`VIPS_IDX_W-1:0] enter_id
);
    // ------------------------------------------------------------
    // Decode and steps
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Word slots of the priority block and of the six status views
    wire is_prio = reg_addr[11:5] == 7'h20 && reg_addr[1:0] == 2'h0;
    wire is_map = is_prio || (reg_addr[6:0] == 7'h0 && reg_addr[11:7] >= 5'h2
        && reg_addr[11:7] <= 5'h7);

    // Core entry excluded, it would move pending under the read
    sequence s_wr(a);
        reg_wr && reg_addr == a && !handler_enter;
    endsequence
    sequence s_rd(a);
        reg_rd && reg_addr == a && !handler_enter;
    endsequence
    sequence s_prio_rt;
        (reg_wr && is_prio) ##1 (reg_rd && reg_addr == $past(reg_addr));
    endsequence

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read slot");
    a_prio_low_zero: assert property (reg_rd && is_prio |=>
        (reg_rdata & 32'h3f3f3f3f) == 32'h0) else $error("priority low bits not zero");
    a_unmapped_zero: assert property (reg_rd && !is_map |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_prio_store: assert property (s_prio_rt |=>
        reg_rdata == ($past(reg_wdata, 2) & 32'hc0c0c0c0)) else $error("priority word lost");
    a_ena_set_view: assert property (s_wr(12'h100) ##1 s_rd(12'h180) |=>
        (reg_rdata & $past(reg_wdata, 2)) == $past(reg_wdata, 2)) else $error("enable not set");
    a_ena_clr_view: assert property (s_wr(12'h180) ##1 s_rd(12'h100) |=>
        (reg_rdata & $past(reg_wdata, 2)) == 32'h0) else $error("enable not cleared");
    a_pend_set_view: assert property (s_wr(12'h200) ##1 s_rd(12'h200) |=>
        (reg_rdata & $past(reg_wdata, 2)) == $past(reg_wdata, 2)) else $error("pend not set");
    a_enter_takes: assert property (handler_enter && irq_valid && enter_id == irq_id |=>
        !(irq_valid && irq_id == $past(enter_id))) else $error("taken line still offered");
    a_valid_reset: assert property ($fell(rst) |-> !irq_valid)
        else $error("line offered after reset");
endmodule

bind vips_top vips_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_valid(irq_valid), .irq_id(irq_id), .handler_enter(handler_enter),
    .enter_id(enter_id));

//--- test/vips_core_model.sv
/* Model of the processor core that takes offered lines.
   Assumes the bench gates taking with take_en and sets the dwell. */
`timescale 1ns/1ps

module vips_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bench control
    input wire logic take_en,
    input wire logic [7:0] dwell,
    // Controller side
    input wire logic irq_valid,
    input wire logic [4:0] irq_id,
    output logic handler_enter,
    output logic [4:0] enter_id,
    output logic handler_exit,
    output logic [4:0] exit_id
);
    // ------------------------------------------------------------
    // Handler sequencing
    // ------------------------------------------------------------
    logic busy_ff;
    logic [7:0] cnt_ff;

    // One handler at a time; exit always names the line last entered
    always @(posedge ref_clk) begin
        handler_enter <= 1'b0;
        handler_exit <= 1'b0;
        if (rst) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h0;
            enter_id <= 5'h0;
            exit_id <= 5'h0;
        end else if (!busy_ff && take_en && irq_valid) begin
            handler_enter <= 1'b1;
            enter_id <= irq_id;
            busy_ff <= 1'b1;
            cnt_ff <= dwell;
        end else if (busy_ff && cnt_ff == 8'h0) begin
            handler_exit <= 1'b1;
            exit_id <= enter_id;
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 8'h1;
        end
    end
endmodule

//--- test/vips_top_tb_top.sv
/* Self-checking bench for the interrupt state block with a core model.
   Assumes the checker is bound in and the package is compiled first. */
`timescale 1ns/1ps

module vips_top_tb_top;
    // ------------------------------------------------------------
    // Signals and reference model
    // ------------------------------------------------------------
    logic ref_clk, rst, reg_wr, reg_rd, irq_valid, handler_enter, handler_exit, take_en;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, irq_req, rdv;
    logic [4:0] irq_id, enter_id, exit_id;
    logic [1:0] irq_prio;
    logic [7:0] dwell;
    int n_mismatch = 0, samples_checked = 0;
    int m_ena = 0, m_pend = 0, m_act = 0, m_lvl = 0, m_line = 0, m_prio[32];

    vips_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_req(irq_req), .irq_valid(irq_valid), .irq_id(irq_id), .irq_prio(irq_prio),
        .handler_enter(handler_enter), .enter_id(enter_id),
        .handler_exit(handler_exit), .exit_id(exit_id));
    vips_core_model u_core (.ref_clk(ref_clk), .rst(rst), .take_en(take_en),
        .dwell(dwell), .irq_valid(irq_valid), .irq_id(irq_id),
        .handler_enter(handler_enter), .enter_id(enter_id),
        .handler_exit(handler_exit), .exit_id(exit_id));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Strobe stays up on return so back-to-back cycles never double-assign
    task wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task cyc(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
        chk(rdv, e);
        @(posedge ref_clk);
    endtask

    // Pulse held one whole cycle, then four idle cycles before returning
    task pulse(input int i);
        irq_req[i] <= 1'b1;
        @(posedge ref_clk);
        irq_req[i] <= 1'b0;
        m_pend |= 1 << i;
        cyc(4);
    endtask

    // Waits for core entry or exit and applies it to the model
    task hnd(input bit ex);
        int v;
        v = 0;
        while ((ex ? handler_exit : handler_enter) !== 1'b1 && v < 100) begin
            @(posedge ref_clk);
            v++;
        end
        take_en <= 1'b0;
        if (ex) begin
            m_act &= ~(1 << exit_id);
            if (m_lvl[exit_id]) m_pend = (m_pend & ~(1 << exit_id)) | (m_line & (1 << exit_id));
        end else begin
            m_act |= 1 << enter_id;
            m_pend &= ~(1 << enter_id);
        end
        cyc(1);
    endtask

    // Lowest priority value wins, strict compare keeps the lowest line
    function int winner();
        int b;
        b = -1;
        for (int i = 0; i < 32; i++)
            if (((m_pend & m_ena & ~m_act) >> i) & 1)
                if (b < 0 || m_prio[i] < m_prio[b]) b = i;
        return b;
    endfunction

    initial begin
        #3000000;
        n_mismatch++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int k, w, v;
        rst = 1'b1;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        irq_req = 32'h0;
        take_en = 1'b0;
        dwell = 8'h28;
        w = $urandom(32'h4ff810d2);
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // Reset values of every view, then two holes in the map
        for (k = 0; k < 14; k++)
            rdc(k < 6 ? 12'h100 + k * 128 : 12'h3e8 + k * 4, 32'h0);
        rdc(12'h104, 32'h0);
        rdc(12'h420, 32'h0);
        // Priority words, random data, read straight back
        for (k = 0; k < 8; k++) begin
            w = $urandom;
            wr(12'h400 + k * 4, w);
            for (v = 0; v < 4; v++) m_prio[k * 4 + v] = (w >> (8 * v + 6)) & 3;
            rdc(12'h400 + k * 4, w & 32'hc0c0c0c0);
        end
        // Enable set and clear through the opposite view
        w = $urandom;
        wr(12'h100, w);
        m_ena |= w;
        rdc(12'h180, m_ena);
        w = $urandom;
        wr(12'h180, w);
        m_ena &= ~w;
        rdc(12'h100, m_ena);
        // Arbitration over random pending sets, all enabled
        wr(12'h100, 32'hffffffff);
        m_ena = -1;
        repeat (8) begin
            w = $urandom;
            wr(12'h200, w);
            m_pend = w;
            rdc(12'h200, m_pend);
            k = winner();
            chk(irq_valid, k >= 0);
            chk(irq_id, k);
            chk(irq_prio, m_prio[k]);
            wr(12'h280, w);
            m_pend = 0;
        end
        // Disabled line still pends but is never offered
        wr(12'h180, 32'h1);
        m_ena &= ~1;
        pulse(0);
        rdc(12'h200, m_pend);
        chk(irq_valid, 1'b0);
        wr(12'h280, 32'h1);
        m_pend = 0;
        rdc(12'h200, m_pend);
        // Pulse line through a handler with a repeat pulse and a clear
        pulse(5);
        take_en <= 1'b1;
        hnd(1'b0);
        rdc(12'h300, m_act);
        rdc(12'h200, m_pend);
        pulse(5);
        rdc(12'h200, m_pend);
        wr(12'h280, 32'h20);
        m_pend = 0;
        rdc(12'h300, m_act);
        rdc(12'h200, m_pend);
        pulse(5);
        hnd(1'b1);
        rdc(12'h200, m_pend);
        take_en <= 1'b1;
        hnd(1'b0);
        hnd(1'b1);
        rdc(12'h300, m_act);
        rdc(12'h200, m_pend);
        // Level line held high across clear, entry and exit
        wr(12'h380, 32'h200);
        m_lvl = 32'h200;
        irq_req[9] <= 1'b1;
        m_line = 32'h200;
        m_pend |= m_line;
        cyc(4);
        wr(12'h280, 32'h200);
        m_pend &= ~(32'h200 & ~(m_lvl & m_line));
        rdc(12'h200, m_pend);
        take_en <= 1'b1;
        hnd(1'b0);
        rdc(12'h200, m_pend);
        hnd(1'b1);
        rdc(12'h200, m_pend);
        irq_req[9] <= 1'b0;
        m_line = 0;
        cyc(4);
        wr(12'h280, 32'h200);
        m_pend &= ~(32'h200 & ~(m_lvl & m_line));
        rdc(12'h200, m_pend);
        finish_test();
    end
endmodule
